// File: src/regs_pkg.sv
// Purpose: Shared constants and carriers for the output control registers
// Assumes: Byte-wide registers behind a parallel access port
// Notes: Per-channel registers are copied once per channel target
package regs_pkg;

    localparam int ADDR_W = 13;
    localparam int DATA_W = 8;
    localparam int NUM_CHAN = 2;

    // ------------------------------------------------------------
    // Register addresses
    // ------------------------------------------------------------
    localparam logic [12:0] ADDR_CHANNEL_INDEX = 13'h0005;
    localparam logic [12:0] ADDR_POWER_MODE = 13'h0008;
    localparam logic [12:0] ADDR_ENHANCEMENT = 13'h000C;
    localparam logic [12:0] ADDR_OUTPUT_MODE = 13'h0014;
    localparam logic [12:0] ADDR_DRIVER_ADJUST = 13'h0015;
    localparam logic [12:0] ADDR_CLOCK_PHASE = 13'h0016;
    localparam logic [12:0] ADDR_COMMIT = 13'h00FF;
    localparam logic [12:0] ADDR_OVERRIDE = 13'h0100;

    // ------------------------------------------------------------
    // Writable bit masks (open bits read zero)
    // ------------------------------------------------------------
    localparam logic [7:0] MASK_CHANNEL_INDEX = 8'h03;
    localparam logic [7:0] MASK_POWER_MODE = 8'h03;
    localparam logic [7:0] MASK_ENHANCEMENT = 8'h04;
    localparam logic [7:0] MASK_OUTPUT_MODE = 8'h45;
    localparam logic [7:0] MASK_DRIVER_ADJUST = 8'h31;
    localparam logic [7:0] MASK_CLOCK_PHASE = 8'h7F;
    localparam logic [7:0] MASK_OVERRIDE = 8'h77;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [7:0] RST_CHANNEL_INDEX = 8'h03;
    localparam logic [7:0] RST_POWER_MODE = 8'h00;
    localparam logic [7:0] RST_ENHANCEMENT = 8'h00;
    localparam logic [7:0] RST_OUTPUT_MODE = 8'h01;
    localparam logic [7:0] RST_DRIVER_ADJUST = 8'h00;
    localparam logic [7:0] RST_CLOCK_PHASE = 8'h03;
    localparam logic [7:0] RST_OVERRIDE = 8'h00;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int BIT_CHOP = 2;
    localparam int BIT_REDUCED_RANGE = 6;
    localparam int BIT_INVERT = 2;
    localparam int BIT_TWOS_COMP = 0;
    localparam int BIT_TERM_HI = 5;
    localparam int BIT_TERM_LO = 4;
    localparam int BIT_DRIVE_DOUBLE = 0;
    localparam int BIT_IN_PHASE_HI = 6;
    localparam int BIT_IN_PHASE_LO = 4;
    localparam int BIT_OUT_PHASE_HI = 3;
    localparam int BIT_OUT_PHASE_LO = 0;
    localparam int BIT_COMMIT = 0;

    localparam logic [3:0] OUT_PHASE_MAX = 4'hB;
    localparam logic [1:0] TERM_NONE = 2'h0;
    localparam logic [1:0] CUR_STANDARD = 2'h2;
    localparam logic [1:0] CUR_REDUCED = 2'h1;

    typedef enum {
        PWR_NORMAL,
        PWR_DOWN,
        PWR_STANDBY,
        PWR_DIG_RESET
    } power_state_t;

    typedef struct packed {
        logic [7:0] output_mode;
        logic [7:0] driver_adjust;
        logic [7:0] clock_phase;
    } chan_regs_t;

    typedef struct packed {
        logic reduced_range;
        logic invert;
        logic twos_comp;
        logic [1:0] termination;
        logic drive_double;
        logic [1:0] drive_current;
        logic [2:0] input_phase;
        logic [3:0] clock_phase;
    } chan_cfg_t;

    typedef struct packed {
        logic clk_en;
        logic reset;
        logic out_en;
    } datapath_ctl_t;

endpackage

// File: src/chan_reg.sv
// Purpose: One channel's copy of the per-channel output registers
// Assumes: Write strobe already qualified by the channel index
// Notes: Effective settings come out of flip-flops
`timescale 1ns/1ps
module chan_reg
    import regs_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst_sync_n,
    input wire logic wr_en,
    input wire logic [ADDR_W-1:0] addr,
    input wire logic [DATA_W-1:0] wdata,
    output chan_regs_t regs,
    output chan_cfg_t cfg
);

    chan_regs_t next_regs;
    chan_cfg_t next_cfg;

    // ------------------------------------------------------------
    // Register storage
    // ------------------------------------------------------------
    always_comb begin
        next_regs = regs;
        if (wr_en) begin
            case (addr)
                ADDR_OUTPUT_MODE: begin
                    next_regs.output_mode = wdata & MASK_OUTPUT_MODE; // [RULE21]
                end
                ADDR_DRIVER_ADJUST: begin
                    next_regs.driver_adjust = wdata & MASK_DRIVER_ADJUST;
                end
                ADDR_CLOCK_PHASE: begin
                    next_regs.clock_phase = wdata & MASK_CLOCK_PHASE;
                end
                default: begin
                    next_regs = regs;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Effective settings
    // ------------------------------------------------------------
    always_comb begin
        next_cfg.reduced_range = next_regs.output_mode[BIT_REDUCED_RANGE]; // [RULE10]
        next_cfg.invert = next_regs.output_mode[BIT_INVERT]; // [RULE12]
        next_cfg.twos_comp = next_regs.output_mode[BIT_TWOS_COMP]; // [RULE13]
        next_cfg.termination =
            next_regs.driver_adjust[BIT_TERM_HI:BIT_TERM_LO]; // [RULE14]
        next_cfg.drive_double =
            next_regs.driver_adjust[BIT_DRIVE_DOUBLE] &&
            (next_cfg.termination == TERM_NONE); // [RULE15] [RULE16]
        next_cfg.drive_current = next_cfg.reduced_range ?
            CUR_REDUCED : CUR_STANDARD; // [RULE11]
        next_cfg.input_phase =
            next_regs.clock_phase[BIT_IN_PHASE_HI:BIT_IN_PHASE_LO]; // [RULE17]
        next_cfg.clock_phase =
            next_regs.clock_phase[BIT_OUT_PHASE_HI:BIT_OUT_PHASE_LO];
        if (next_cfg.clock_phase > OUT_PHASE_MAX) begin
            next_cfg.clock_phase = OUT_PHASE_MAX; // [RULE19]
        end
    end

    always_ff @(posedge sys_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            regs.output_mode <= RST_OUTPUT_MODE;
            regs.driver_adjust <= RST_DRIVER_ADJUST;
            regs.clock_phase <= RST_CLOCK_PHASE;
            cfg <= '0;
            cfg.twos_comp <= RST_OUTPUT_MODE[BIT_TWOS_COMP];
            cfg.drive_current <= CUR_STANDARD;
            cfg.clock_phase <= RST_CLOCK_PHASE[BIT_OUT_PHASE_HI:0];
        end else begin
            regs <= next_regs;
            cfg <= next_cfg;
        end
    end

endmodule

// File: src/adc_output_control_regs.sv
// Purpose: Control register bank of a dual-channel converter
// Assumes: Serial port framing decoded into byte accesses on sys_clk
// Notes: Only rst_n (power-on reset) clears this block
//
// Overview of operation
// RULE1 - Index low bits pick per-channel write targets
// RULE2 - Writes apply at once except override register
// RULE3 - Override applies on commit bit zero write
// RULE4 - Mode 00 keeps both channels fully active
// RULE5 - Mode 01 gates clocks, resets, disables outputs
// RULE6 - Mode 10 gates clocks, disables outputs only
// RULE7 - Mode 11 resets datapath, not the port
// RULE8 - Only power-on reset resets the port
// RULE9 - Enhancement bit 2 enables first stage chopping
// RULE10 - Output mode bit 6 picks reduced range
// RULE11 - Driver current follows range automatically
// RULE12 - Output mode bit 2 inverts serial stream
// RULE13 - Bit 0 set twos complement, clear offset
// RULE14 - Adjust bits 5:4 pick driver termination
// RULE15 - Adjust bit 0 doubles clock output drive
// RULE16 - Termination overrides double drive strength
// RULE17 - Input phase delays sampling 0 to 7
// RULE18 - Host keeps input phase within divider
// RULE19 - Output clock phase code times 60 degrees
// RULE20 - Host writes 03 then 00 for reset
// RULE21 - Open bits ignore writes, read zero
`timescale 1ns/1ps
module adc_output_control_regs
    import regs_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic reg_wr_en,
    input wire logic reg_rd_en,
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic [DATA_W-1:0] reg_wdata,
    output logic [DATA_W-1:0] reg_rdata,
    output logic reg_rvalid,
    output datapath_ctl_t datapath_ctl,
    output logic chop_en,
    output logic [DATA_W-1:0] override_active,
    output chan_cfg_t chan_cfg [NUM_CHAN]
);

    // ------------------------------------------------------------
    // Reset release
    // ------------------------------------------------------------
    logic rst_meta_n;
    logic rst_sync_n;

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_meta_n <= 1'b0;
            rst_sync_n <= 1'b0;
        end else begin
            rst_meta_n <= 1'b1;
            rst_sync_n <= rst_meta_n; // [RULE8]
        end
    end

    // ------------------------------------------------------------
    // Global registers
    // ------------------------------------------------------------
    logic [7:0] channel_index;
    logic [7:0] power_mode_select;
    logic [7:0] enhancement_control;
    logic [7:0] override_pending;
    logic [7:0] next_channel_index;
    logic [7:0] next_power_mode_select;
    logic [7:0] next_enhancement_control;
    logic [7:0] next_override_pending;
    logic [7:0] next_override_active;
    logic commit_hit;

    always_comb begin
        next_channel_index = channel_index;
        next_power_mode_select = power_mode_select;
        next_enhancement_control = enhancement_control;
        next_override_pending = override_pending;
        next_override_active = override_active;
        commit_hit = 1'b0;
        if (reg_wr_en) begin
            case (reg_addr)
                ADDR_CHANNEL_INDEX: begin
                    next_channel_index = reg_wdata & MASK_CHANNEL_INDEX;
                end
                ADDR_POWER_MODE: begin
                    next_power_mode_select = reg_wdata & MASK_POWER_MODE;
                end
                ADDR_ENHANCEMENT: begin
                    next_enhancement_control = reg_wdata & MASK_ENHANCEMENT;
                end
                ADDR_OVERRIDE: begin
                    next_override_pending = reg_wdata & MASK_OVERRIDE; // [RULE2]
                end
                ADDR_COMMIT: begin
                    commit_hit = reg_wdata[BIT_COMMIT];
                end
                default: begin
                    commit_hit = 1'b0;
                end
            endcase
        end
        if (commit_hit) begin
            next_override_active = override_pending; // [RULE3]
        end
    end

    always_ff @(posedge sys_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            channel_index <= RST_CHANNEL_INDEX;
            power_mode_select <= RST_POWER_MODE;
            enhancement_control <= RST_ENHANCEMENT;
            override_pending <= RST_OVERRIDE;
            override_active <= RST_OVERRIDE;
        end else begin
            channel_index <= next_channel_index;
            power_mode_select <= next_power_mode_select;
            enhancement_control <= next_enhancement_control;
            override_pending <= next_override_pending;
            override_active <= next_override_active;
        end
    end

    // ------------------------------------------------------------
    // Power modes and chopping
    // ------------------------------------------------------------
    power_state_t power_state;
    datapath_ctl_t next_datapath_ctl;
    logic next_chop_en;

    always_comb begin
        case (next_power_mode_select[1:0])
            2'h0: power_state = PWR_NORMAL;
            2'h1: power_state = PWR_DOWN;
            2'h2: power_state = PWR_STANDBY;
            default: power_state = PWR_DIG_RESET;
        endcase
        case (power_state)
            PWR_NORMAL: begin
                next_datapath_ctl = '{clk_en: 1'b1, reset: 1'b0,
                    out_en: 1'b1}; // [RULE4]
            end
            PWR_DOWN: begin
                next_datapath_ctl = '{clk_en: 1'b0, reset: 1'b1,
                    out_en: 1'b0}; // [RULE5]
            end
            PWR_STANDBY: begin
                next_datapath_ctl = '{clk_en: 1'b0, reset: 1'b0,
                    out_en: 1'b0}; // [RULE6]
            end
            default: begin
                next_datapath_ctl = '{clk_en: 1'b1, reset: 1'b1,
                    out_en: 1'b0}; // [RULE7] [RULE20]
            end
        endcase
        next_chop_en = next_enhancement_control[BIT_CHOP]; // [RULE9]
    end

    always_ff @(posedge sys_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            datapath_ctl <= '{clk_en: 1'b1, reset: 1'b0, out_en: 1'b1};
            chop_en <= 1'b0;
        end else begin
            datapath_ctl <= next_datapath_ctl;
            chop_en <= next_chop_en;
        end
    end

    // ------------------------------------------------------------
    // Per-channel registers
    // ------------------------------------------------------------
    chan_regs_t chan_regs [NUM_CHAN];
    logic [NUM_CHAN-1:0] chan_wr;

    for (genvar c = 0; c < NUM_CHAN; c++) begin : g_chan
        assign chan_wr[c] = reg_wr_en && channel_index[c]; // [RULE1]
        chan_reg u_chan (
            .sys_clk(sys_clk),
            .rst_sync_n(rst_sync_n),
            .wr_en(chan_wr[c]),
            .addr(reg_addr),
            .wdata(reg_wdata),
            .regs(chan_regs[c]),
            .cfg(chan_cfg[c])
        );
    end

    // ------------------------------------------------------------
    // Read path
    // ------------------------------------------------------------
    chan_regs_t sel_regs;
    logic [DATA_W-1:0] next_reg_rdata;

    always_comb begin
        sel_regs = chan_regs[0];
        if (!channel_index[0] && channel_index[1]) begin
            sel_regs = chan_regs[1];
        end
        case (reg_addr)
            ADDR_CHANNEL_INDEX: next_reg_rdata = channel_index;
            ADDR_POWER_MODE: next_reg_rdata = power_mode_select;
            ADDR_ENHANCEMENT: next_reg_rdata = enhancement_control;
            ADDR_OUTPUT_MODE: next_reg_rdata = sel_regs.output_mode;
            ADDR_DRIVER_ADJUST: next_reg_rdata = sel_regs.driver_adjust;
            ADDR_CLOCK_PHASE: next_reg_rdata = sel_regs.clock_phase;
            ADDR_OVERRIDE: next_reg_rdata = override_pending;
            default: next_reg_rdata = 8'h00; // [RULE21]
        endcase
        if (!reg_rd_en) begin
            next_reg_rdata = reg_rdata;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            reg_rdata <= 8'h00;
            reg_rvalid <= 1'b0;
        end else begin
            reg_rdata <= next_reg_rdata;
            reg_rvalid <= reg_rd_en;
        end
    end

endmodule

// File: tb/adc_output_control_regs_assertions.sv
// Purpose: Port-level checks of the output control register bank
// Assumes: Bound to the top module, one clock domain
// Notes: Effects are expected one cycle after a taken write
`timescale 1ns/1ps
module adc_output_control_regs_assertions
    import regs_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic reg_wr_en,
    input wire logic reg_rd_en,
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic [DATA_W-1:0] reg_wdata,
    input wire logic [DATA_W-1:0] reg_rdata,
    input wire logic reg_rvalid,
    input wire datapath_ctl_t datapath_ctl,
    input wire logic chop_en,
    input wire logic [DATA_W-1:0] override_active,
    input wire chan_cfg_t chan_cfg [NUM_CHAN]
);
    // ------------------------------------------------------------
    // Helper logic
    // ------------------------------------------------------------
    wire pw = reg_wr_en && reg_addr == ADDR_POWER_MODE;
    wire ow = reg_wr_en && reg_addr == ADDR_OUTPUT_MODE;
    wire cw = reg_wr_en && reg_addr == ADDR_COMMIT && reg_wdata[BIT_COMMIT];
    logic [7:0] pend;

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n)
            pend <= RST_OVERRIDE;
        else if (reg_wr_en && reg_addr == ADDR_OVERRIDE)
            pend <= reg_wdata & MASK_OVERRIDE;
    end

    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    AST_PWR_NORMAL: assert property (
        pw && reg_wdata[1:0] == 2'h0 |=> datapath_ctl == 3'h5)
        else $error("mode 00 controls wrong");
    AST_PWR_DOWN: assert property (
        pw && reg_wdata[1:0] == 2'h1 |=> datapath_ctl == 3'h2)
        else $error("mode 01 controls wrong");
    AST_PWR_STANDBY: assert property (
        pw && reg_wdata[1:0] == 2'h2 |=> datapath_ctl == 3'h0)
        else $error("mode 10 controls wrong");
    AST_PWR_DIG_RESET: assert property (
        pw && reg_wdata[1:0] == 2'h3 |=> datapath_ctl == 3'h6)
        else $error("mode 11 controls wrong");
    AST_CHOP: assert property (
        reg_wr_en && reg_addr == ADDR_ENHANCEMENT
        |=> chop_en == $past(reg_wdata[BIT_CHOP]))
        else $error("chop enable wrong");
    AST_OVR_HOLD: assert property (
        !cw |=> $stable(override_active))
        else $error("override changed without commit");
    AST_OVR_COMMIT: assert property (
        cw |=> override_active == $past(pend))
        else $error("override not applied on commit");
    AST_RVALID: assert property (
        reg_rvalid == $past(reg_rd_en))
        else $error("read valid pulse wrong");
    AST_INVERT_CAUSE: assert property (
        !$stable(chan_cfg[0].invert) |-> $past(ow))
        else $error("invert changed without write");
    AST_CURRENT: assert property (
        chan_cfg[0].drive_current ==
        (chan_cfg[0].reduced_range ? CUR_REDUCED : CUR_STANDARD))
        else $error("driver current wrong");
    AST_TERM_WINS: assert property (
        chan_cfg[1].termination != TERM_NONE |-> !chan_cfg[1].drive_double)
        else $error("double drive with termination");

    cover property (pw && reg_wdata[1:0] == 2'h3);
    cover property (cw);
    cover property (chan_cfg[1].termination != TERM_NONE);
endmodule

// File: tb/host_model.sv
// Purpose: Host model driving the register access port
// Assumes: Byte accesses, read answer one cycle after the strobe
// Notes: Idle address and data lines show the inverted last value
`timescale 1ns/1ps
module host_model
    import regs_pkg::*;
#(
    parameter logic [2:0] DIVIDER = 3'h7
)
(
    input wire logic sys_clk,
    input wire logic [DATA_W-1:0] reg_rdata,
    input wire logic reg_rvalid,
    output logic reg_wr_en,
    output logic reg_rd_en,
    output logic [ADDR_W-1:0] reg_addr,
    output logic [DATA_W-1:0] reg_wdata
);
    initial begin
        reg_wr_en = 1'b0;
        reg_rd_en = 1'b0;
        reg_addr = 13'h1FFF;
        reg_wdata = 8'h00;
    end

    task automatic wr(input logic [12:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        reg_wr_en <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge sys_clk);
        reg_wr_en <= 1'b0;
        reg_addr <= ~a;
        reg_wdata <= ~d;
    endtask

    task automatic rd(input logic [12:0] a, output logic [7:0] d);
        @(posedge sys_clk);
        reg_rd_en <= 1'b1;
        reg_addr <= a;
        @(posedge sys_clk);
        reg_rd_en <= 1'b0;
        reg_addr <= ~a;
        @(posedge sys_clk);
        d = (reg_rvalid === 1'b1) ? reg_rdata : 8'hXX;
    endtask

    task automatic commit();
        wr(ADDR_COMMIT, 8'h01);
    endtask

    task automatic digital_reset();
        wr(ADDR_POWER_MODE, 8'h03);
        wr(ADDR_POWER_MODE, 8'h00);
    endtask

    task automatic set_phase(input logic [2:0] ip, input logic [3:0] op);
        logic [2:0] lim;
        lim = (ip > DIVIDER) ? DIVIDER : ip;
        wr(ADDR_CLOCK_PHASE, {1'b0, lim, op});
    endtask
endmodule

// File: tb/adc_output_control_regs_tb_top.sv
// Purpose: Self-checking bench for the output control register bank
// Assumes: Host model drives every register port input
// Notes: Reset readback and mask expectations come from the register constants, the rest are literals
`timescale 1ns/1ps
module adc_output_control_regs_tb_top;
    import regs_pkg::*;
    logic sys_clk = 1'b0;
    logic rst_n = 1'b0;
    logic reg_wr_en, reg_rd_en, reg_rvalid, chop_en;
    logic [ADDR_W-1:0] reg_addr;
    logic [DATA_W-1:0] reg_wdata, reg_rdata, override_active, got;
    datapath_ctl_t datapath_ctl;
    chan_cfg_t chan_cfg [NUM_CHAN];
    int n_errors = 0;
    int checks_done = 0;
    logic [12:0] addrs [6] = '{ADDR_CHANNEL_INDEX, ADDR_POWER_MODE,
        ADDR_ENHANCEMENT, ADDR_OUTPUT_MODE, ADDR_DRIVER_ADJUST,
        ADDR_CLOCK_PHASE};
    logic [7:0] masks [6] = '{MASK_CHANNEL_INDEX, MASK_POWER_MODE,
        MASK_ENHANCEMENT, MASK_OUTPUT_MODE, MASK_DRIVER_ADJUST,
        MASK_CLOCK_PHASE};
    logic [7:0] rsts [6] = '{RST_CHANNEL_INDEX, RST_POWER_MODE,
        RST_ENHANCEMENT, RST_OUTPUT_MODE, RST_DRIVER_ADJUST,
        RST_CLOCK_PHASE};
    logic [7:0] pwr_exp [4] = '{8'h05, 8'h02, 8'h00, 8'h06};

    always #10 sys_clk = ~sys_clk;

    host_model host (.sys_clk, .reg_rdata, .reg_rvalid, .reg_wr_en,
        .reg_rd_en, .reg_addr, .reg_wdata);
    adc_output_control_regs dut (.sys_clk, .rst_n, .reg_wr_en, .reg_rd_en,
        .reg_addr, .reg_wdata, .reg_rdata, .reg_rvalid, .datapath_ctl,
        .chop_en, .override_active, .chan_cfg);

    // ------------------------------------------------------------
    // Compare and closing tasks
    // ------------------------------------------------------------
    function automatic logic [7:0] om(input chan_cfg_t c);
        return {3'h0, c.reduced_range, c.invert, c.twos_comp,
            c.drive_current};
    endfunction

    task automatic check(input string what, input logic [7:0] exp,
        input logic [7:0] seen);
        checks_done++;
        if (seen !== exp) begin
            n_errors++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic rd_check(input logic [12:0] a, input logic [7:0] exp);
        host.rd(a, got);
        check($sformatf("read %h", a), exp, got);
    endtask

    task automatic tally_and_finish();
        $display("errors %0d checks %0d", n_errors, checks_done);
        if (n_errors == 0 && checks_done > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    // ------------------------------------------------------------
    // Test sequence
    // ------------------------------------------------------------
    initial begin
        repeat (16) @(posedge sys_clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge sys_clk);
        for (int i = 0; i < 6; i++) begin
            rd_check(addrs[i], rsts[i]);
        end
        check("datapath", 8'h05, 8'(datapath_ctl));
        check("mode ch1", 8'h06, om(chan_cfg[1]));
        rd_check(13'h0007, 8'h00);
        for (int i = 0; i < 6; i++) begin
            host.wr(addrs[i], 8'hFF);
            rd_check(addrs[i], masks[i]);
        end
        check("chop", 8'h01, 8'(chop_en));
        check("mode ch0", 8'h1D, om(chan_cfg[0]));
        check("phase", 8'h7B, {1'b0, chan_cfg[1].input_phase,
            chan_cfg[1].clock_phase});
        check("double", 8'h00, 8'(chan_cfg[0].drive_double));
        for (int i = 0; i < 6; i++) host.wr(addrs[i], rsts[i]);
        #1 check("chop", 8'h00, 8'(chop_en));
        for (int m = 0; m < 4; m++) begin
            host.wr(ADDR_POWER_MODE, 8'(m));
            #1 check("datapath", pwr_exp[m], 8'(datapath_ctl));
            rd_check(ADDR_CHANNEL_INDEX, 8'h03);
        end
        host.digital_reset();
        #1 check("datapath", 8'h05, 8'(datapath_ctl));
        host.wr(ADDR_CHANNEL_INDEX, 8'h01);
        host.wr(ADDR_OUTPUT_MODE, 8'h44);
        #1 check("mode ch0", 8'h19, om(chan_cfg[0]));
        check("mode ch1", 8'h06, om(chan_cfg[1]));
        rd_check(ADDR_OUTPUT_MODE, 8'h44);
        host.wr(ADDR_CHANNEL_INDEX, 8'h02);
        host.wr(ADDR_DRIVER_ADJUST, 8'h01);
        #1 check("dbl ch1", 8'h01, 8'(chan_cfg[1].drive_double));
        check("dbl ch0", 8'h00, 8'(chan_cfg[0].drive_double));
        host.wr(ADDR_DRIVER_ADJUST, 8'h11);
        #1 check("term", 8'h10, {2'h0, chan_cfg[1].termination,
            3'h0, chan_cfg[1].drive_double});
        host.set_phase(3'h5, 4'h9);
        rd_check(ADDR_CLOCK_PHASE, 8'h59);
        check("phase ch1", 8'h59, {1'b0, chan_cfg[1].input_phase,
            chan_cfg[1].clock_phase});
        host.wr(ADDR_OVERRIDE, 8'hD7);
        #1 check("override", 8'h00, override_active);
        host.wr(ADDR_COMMIT, 8'h00);
        #1 check("override", 8'h00, override_active);
        host.commit();
        #1 check("override", 8'h57, override_active);
        rd_check(ADDR_COMMIT, 8'h00);
        rst_n <= 1'b0;
        repeat (2) @(posedge sys_clk);
        check("override", 8'h00, override_active);
        rst_n <= 1'b1;
        repeat (3) @(posedge sys_clk);
        rd_check(ADDR_CHANNEL_INDEX, RST_CHANNEL_INDEX);
        tally_and_finish();
    end

    initial begin
        #400000;
        n_errors++;
        $display("watchdog expired");
        tally_and_finish();
    end
endmodule

bind adc_output_control_regs adc_output_control_regs_assertions chk (
    .sys_clk, .rst_n, .reg_wr_en, .reg_rd_en, .reg_addr, .reg_wdata,
    .reg_rdata, .reg_rvalid, .datapath_ctl, .chop_en, .override_active,
    .chan_cfg);
